// *** fsd_pkg.sv ***
// Behaviour
// - Start sequence valid for 1..len+2 low bits
// - First low bit strobe after start marks secondary point
// - Latch microtick stamp at secondary point
// - Primary stamp is secondary minus correction terms
// - Primary stamp delivered with decoded frame
// - Both stamps counted in microticks
// - Pulse potential frame start at secondary point
// - Only one decoding method per channel
// - Wakeup detection off only during reset, transmit, standby
// - Elements separated by idle delimiter decode cleanly
// - Each channel decodes independently
// - Bit time equals samples per bit times period
// - Microtick is integer multiple, phase locked
// - Element start at first low after idle
// - Idle only if all delimiter bits high
// - Pulse potential idle start on low-to-high bits
// - Strobe bit where sample counter hits offset
// - Idle timer restarts on each low bit
package fsd_pkg;

  localparam int SAMPLE_CLOCK_PERIOD_NS = 5;
  localparam int SAMPLES_PER_BIT_INT = 8;
  localparam int NOMINAL_BIT_TIME_NS = SAMPLES_PER_BIT_INT * SAMPLE_CLOCK_PERIOD_NS;
  localparam int IDLE_DELIMITER_BITS_INT = 11;

  localparam int SCNT_W = 4;
  localparam int UTICK_W = 16;
  localparam int ICNT_W = 7;

  localparam logic [SCNT_W-1:0] SAMPLES_PER_BIT = 4'h8;
  localparam logic [SCNT_W-1:0] STROBE_SAMPLE_INDEX = 4'h5;
  localparam logic [SCNT_W-1:0] SYNC_RELOAD_VALUE = 4'h2;
  localparam logic [SCNT_W-1:0] SCNT_RESET_VALUE = 4'h1;
  localparam logic [ICNT_W-1:0] IDLE_SAMPLES =
    ICNT_W'(IDLE_DELIMITER_BITS_INT * SAMPLES_PER_BIT_INT);
  localparam logic [4:0] TSS_TOLERANCE_BITS = 5'h02;
  localparam logic [1:0] MAX_FSS_HIGH_BITS = 2'h3;
  localparam logic [UTICK_W-1:0] UTICK_RESET_VALUE = 16'h0000;

  typedef enum logic [1:0] {
    FSD_STANDBY,
    FSD_NORMAL,
    FSD_READY
  } fsd_mode_t;

  typedef enum logic [1:0] {
    DS_WAIT_IDLE,
    DS_START_SEQ,
    DS_FRAME_START,
    DS_FRAME
  } fsd_dec_state_t;

  typedef struct packed {
    logic [3:0] tx_start_seq_len;
    logic [2:0] samples_per_utick;
    logic [UTICK_W-1:0] decode_correction;
    logic [UTICK_W-1:0] delay_compensation;
  } fsd_cfg_t;

  typedef struct packed {
    logic valid;
    logic [31:0] contents;
    logic [UTICK_W-1:0] primary_ref_stamp;
  } fsd_frame_ind_t;

endpackage : fsd_pkg

// *** fsd_wrap_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsd_wrap_counter
  import fsd_pkg::*;
#(
  parameter int W = 4
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  input wire logic [W-1:0] top_in,
  output logic [W-1:0] count_out,
  output logic wrap_out
);

  typedef struct packed {
    logic [W-1:0] count;
  } fsd_wc_state_t;

  fsd_wc_state_t s_r;
  fsd_wc_state_t s_nxt;

  // Counts 1..top cyclically, load has priority
  always_comb
  begin
    s_nxt = s_r;
    if (load_in)
    begin
      s_nxt.count = load_val_in;
    end
    else if (run_in)
    begin
      s_nxt.count = (s_r.count >= top_in) ? W'(1) : W'(s_r.count + W'(1));
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_r <= '{count: W'(1)};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign count_out = s_r.count;
  assign wrap_out = run_in && !load_in && (s_r.count >= top_in);

endmodule : fsd_wrap_counter
`default_nettype wire

// *** fsd_frame_start_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsd_frame_start_decoder
  import fsd_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire fsd_mode_t MODE_IN,
  input wire logic TX_ACTIVE_IN,
  input wire logic VOTED_RX_IN,
  input wire fsd_cfg_t CFG_IN,
  input wire logic FRAME_DONE_IN,
  input wire logic [31:0] FRAME_CONTENTS_IN,
  input wire logic DECODE_ERROR_IN,
  output logic BIT_STROBE_OUT,
  output logic BIT_VALUE_OUT,
  output logic CHANNEL_IDLE_OUT,
  output logic CE_START_OUT,
  output logic POT_FRAME_START_OUT,
  output logic POT_IDLE_START_OUT,
  output logic [UTICK_W-1:0] SECONDARY_REF_STAMP_OUT,
  output fsd_frame_ind_t FRAME_DECODED_OUT,
  output logic START_SEQ_ERROR_OUT,
  output logic SYMBOL_DECODE_EN_OUT,
  output logic WAKEUP_DETECT_EN_OUT,
  output logic [UTICK_W-1:0] UTICK_COUNT_OUT
);

  typedef struct packed {
    logic prev_voted;
    logic sync_en;
    logic last_low;
    logic [ICNT_W-1:0] idle_cnt;
    logic idle;
    fsd_dec_state_t dec_state;
    logic [4:0] low_cnt;
    logic [1:0] high_cnt;
    logic [UTICK_W-1:0] utick;
    logic [UTICK_W-1:0] primary;
    logic [UTICK_W-1:0] secondary;
    logic bit_strobe;
    logic bit_value;
    logic ce_start;
    logic pot_frame_start;
    logic pot_idle_start;
    logic ss_error;
    logic sym_en;
    logic wake_en;
    fsd_frame_ind_t frame_ind;
  } fsd_state_t;

  localparam fsd_state_t STATE_RESET = '{
    prev_voted: 1'b1,
    sync_en: 1'b1,
    last_low: 1'b0,
    idle_cnt: '0,
    idle: 1'b0,
    dec_state: DS_WAIT_IDLE,
    low_cnt: '0,
    high_cnt: '0,
    utick: UTICK_RESET_VALUE,
    primary: UTICK_RESET_VALUE,
    secondary: UTICK_RESET_VALUE,
    bit_strobe: 1'b0,
    bit_value: 1'b1,
    ce_start: 1'b0,
    pot_frame_start: 1'b0,
    pot_idle_start: 1'b0,
    ss_error: 1'b0,
    sym_en: 1'b1,
    wake_en: 1'b0,
    frame_ind: '0
  };

  fsd_state_t s_r;
  fsd_state_t s_nxt;

  logic rx_run;
  logic dec_run;
  logic sync_now;
  logic strobe_now;
  logic [SCNT_W-1:0] sample_cnt;
  logic utick_wrap;
  logic [4:0] tss_max;

  // Receive path halts in standby and while this node transmits
  assign rx_run = (MODE_IN != FSD_STANDBY) && !TX_ACTIVE_IN;
  assign dec_run = rx_run && (MODE_IN == FSD_NORMAL);
  // Bit synchronisation on falling edge of voted samples
  assign sync_now = rx_run && s_r.sync_en && s_r.prev_voted && !VOTED_RX_IN;
  assign strobe_now = rx_run && (sample_cnt == STROBE_SAMPLE_INDEX) && !sync_now;
  assign tss_max = 5'({1'b0, CFG_IN.tx_start_seq_len} + TSS_TOLERANCE_BITS);

  // Sample counter, one sample per system clock
  fsd_wrap_counter #(
    .W(SCNT_W)
  ) u_sample_cnt (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RESET_N_IN),
    .run_in(rx_run),
    .load_in(sync_now),
    .load_val_in(SYNC_RELOAD_VALUE),
    .top_in(SAMPLES_PER_BIT),
    .count_out(sample_cnt),
    .wrap_out()
  );

  // Microtick prescaler, locked to the sample clock
  fsd_wrap_counter #(
    .W(3)
  ) u_utick_pre (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RESET_N_IN),
    .run_in(1'b1),
    .load_in(1'b0),
    .load_val_in(3'h1),
    .top_in(CFG_IN.samples_per_utick),
    .count_out(),
    .wrap_out(utick_wrap)
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.bit_strobe = 1'b0;
    s_nxt.ce_start = 1'b0;
    s_nxt.pot_frame_start = 1'b0;
    s_nxt.pot_idle_start = 1'b0;
    s_nxt.ss_error = 1'b0;
    s_nxt.frame_ind.valid = 1'b0;
    s_nxt.wake_en = (MODE_IN != FSD_STANDBY) && !TX_ACTIVE_IN;

    // Free-running time base in microticks
    if (utick_wrap)
    begin
      s_nxt.utick = UTICK_W'(s_r.utick + UTICK_W'(1));
    end

    s_nxt.prev_voted = rx_run ? VOTED_RX_IN : 1'b1;
    if (sync_now)
    begin
      s_nxt.sync_en = 1'b0;
    end
    if (strobe_now)
    begin
      s_nxt.bit_strobe = 1'b1;
      s_nxt.bit_value = VOTED_RX_IN;
      s_nxt.last_low = !VOTED_RX_IN;
      if (VOTED_RX_IN)
      begin
        s_nxt.sync_en = 1'b1;
      end
      if (VOTED_RX_IN && s_r.last_low)
      begin
        s_nxt.pot_idle_start = 1'b1;
      end
    end

    // Idle timer: cleared while not receiving, restarted by low bits
    if (!rx_run)
    begin
      s_nxt.idle_cnt = '0;
      s_nxt.idle = 1'b0;
      s_nxt.last_low = 1'b0;
    end
    else if (strobe_now && !VOTED_RX_IN)
    begin
      s_nxt.idle_cnt = '0;
      s_nxt.idle = 1'b0;
    end
    else if (!s_r.idle)
    begin
      if (s_r.idle_cnt == ICNT_W'(IDLE_SAMPLES - ICNT_W'(1)))
      begin
        s_nxt.idle = 1'b1;
      end
      else
      begin
        s_nxt.idle_cnt = ICNT_W'(s_r.idle_cnt + ICNT_W'(1));
      end
    end

    if (!dec_run)
    begin
      s_nxt.dec_state = DS_WAIT_IDLE;
    end
    else
    begin
      case (s_r.dec_state)
        DS_WAIT_IDLE:
        begin
          if (s_r.idle && strobe_now && !VOTED_RX_IN)
          begin
            s_nxt.ce_start = 1'b1;
            s_nxt.low_cnt = 5'h01;
            s_nxt.dec_state = DS_START_SEQ;
          end
        end
        DS_START_SEQ:
        begin
          if (strobe_now && !VOTED_RX_IN)
          begin
            if (s_r.low_cnt >= tss_max)
            begin
              s_nxt.ss_error = 1'b1;
              s_nxt.dec_state = DS_WAIT_IDLE;
            end
            else
            begin
              s_nxt.low_cnt = 5'(s_r.low_cnt + 5'h01);
            end
          end
          else if (strobe_now)
          begin
            s_nxt.high_cnt = 2'h1;
            s_nxt.dec_state = DS_FRAME_START;
          end
        end
        DS_FRAME_START:
        begin
          if (strobe_now && !VOTED_RX_IN)
          begin
            // Secondary reference point reached
            s_nxt.secondary = s_r.utick;
            s_nxt.primary = UTICK_W'(s_r.utick - CFG_IN.decode_correction
              - CFG_IN.delay_compensation);
            s_nxt.pot_frame_start = 1'b1;
            s_nxt.dec_state = DS_FRAME;
          end
          else if (strobe_now)
          begin
            if (s_r.high_cnt >= MAX_FSS_HIGH_BITS)
            begin
              s_nxt.ss_error = 1'b1;
              s_nxt.dec_state = DS_WAIT_IDLE;
            end
            else
            begin
              s_nxt.high_cnt = 2'(s_r.high_cnt + 2'h1);
            end
          end
        end
        DS_FRAME:
        begin
          if (DECODE_ERROR_IN || s_r.idle)
          begin
            s_nxt.dec_state = DS_WAIT_IDLE;
          end
          else if (FRAME_DONE_IN)
          begin
            s_nxt.frame_ind.valid = 1'b1;
            s_nxt.frame_ind.contents = FRAME_CONTENTS_IN;
            s_nxt.frame_ind.primary_ref_stamp = s_r.primary;
          end
        end
        default:
        begin
          s_nxt.dec_state = DS_WAIT_IDLE;
        end
      endcase
    end
    // Symbol decoding only until a frame start is classified
    s_nxt.sym_en = (s_nxt.dec_state != DS_FRAME);
  end

  // One channel per instance; no shared state between channels
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      s_r <= STATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign BIT_STROBE_OUT = s_r.bit_strobe;
  assign BIT_VALUE_OUT = s_r.bit_value;
  assign CHANNEL_IDLE_OUT = s_r.idle;
  assign CE_START_OUT = s_r.ce_start;
  assign POT_FRAME_START_OUT = s_r.pot_frame_start;
  assign POT_IDLE_START_OUT = s_r.pot_idle_start;
  assign SECONDARY_REF_STAMP_OUT = s_r.secondary;
  assign FRAME_DECODED_OUT = s_r.frame_ind;
  assign START_SEQ_ERROR_OUT = s_r.ss_error;
  assign SYMBOL_DECODE_EN_OUT = s_r.sym_en;
  assign WAKEUP_DETECT_EN_OUT = s_r.wake_en;
  assign UTICK_COUNT_OUT = s_r.utick;

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  sequence seq_low_strobe;
    strobe_now && !VOTED_RX_IN;
  endsequence

  sequence seq_trp_hit;
    (s_r.dec_state == DS_FRAME_START) && dec_run ##0 seq_low_strobe;
  endsequence

  AST_TSS_TOO_LONG: assert property (
    (s_r.dec_state == DS_START_SEQ) && dec_run ##0 seq_low_strobe
      ##0 (s_r.low_cnt >= tss_max) |=> START_SEQ_ERROR_OUT && SYMBOL_DECODE_EN_OUT)
    else $error("start sequence overlength not flagged");

  AST_TRP_PULSE: assert property (
    seq_trp_hit |=> POT_FRAME_START_OUT && !SYMBOL_DECODE_EN_OUT)
    else $error("no potential frame start at secondary point");

  AST_TRP_STAMP: assert property (
    seq_trp_hit |=> SECONDARY_REF_STAMP_OUT == $past(s_r.utick))
    else $error("secondary stamp not taken from time base");

  AST_PRIMARY_CALC: assert property (
    seq_trp_hit |=> s_r.primary == UTICK_W'(SECONDARY_REF_STAMP_OUT
      - $past(CFG_IN.decode_correction) - $past(CFG_IN.delay_compensation)))
    else $error("primary stamp miscomputed");

  AST_FRAME_DELIVER: assert property (
    (s_r.dec_state == DS_FRAME) && dec_run && FRAME_DONE_IN && !DECODE_ERROR_IN
      && !s_r.idle |=> FRAME_DECODED_OUT.valid
      && (FRAME_DECODED_OUT.primary_ref_stamp == s_r.primary))
    else $error("decoded frame lacks primary stamp");

  AST_POT_IDLE: assert property (
    strobe_now && VOTED_RX_IN && s_r.last_low |=> POT_IDLE_START_OUT)
    else $error("potential idle start missing");

  AST_IDLE_HOLDOFF: assert property (
    seq_low_strobe |=> !CHANNEL_IDLE_OUT [*8])
    else $error("idle declared after a low bit too soon");

  AST_CE_START: assert property (
    (s_r.dec_state == DS_WAIT_IDLE) && dec_run && s_r.idle ##0 seq_low_strobe
      |=> CE_START_OUT ##1 !CE_START_OUT)
    else $error("element start not marked");

  AST_STROBE_POINT: assert property (
    $rose(BIT_STROBE_OUT) |-> $past(sample_cnt) == STROBE_SAMPLE_INDEX)
    else $error("bit strobed off the strobe point");

  AST_SYNC_RELOAD: assert property (
    sync_now && rx_run |=> sample_cnt == SYNC_RELOAD_VALUE)
    else $error("sample counter not realigned");

  AST_WAKE_GATE: assert property (
    TX_ACTIVE_IN |=> !WAKEUP_DETECT_EN_OUT)
    else $error("wakeup detection active during transmit");

endmodule : fsd_frame_start_decoder
`default_nettype wire

// *** fsd_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsd_line_model
  import fsd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic rx_out,
  output logic busy_out
);
  logic lvl_q[$];

  // Released line rests HIGH, as the bus idles recessive
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_out <= 1'b1;
      busy_out <= 1'b0;
    end
    else
    begin
      rx_out <= (lvl_q.size() > 0) ? lvl_q.pop_front() : 1'b1;
      busy_out <= (lvl_q.size() != 0);
    end
  end

  // Whole bits only, queued off the clock edge
  task automatic put_bits(input logic lvl, input int nbits);
    #1;
    repeat (nbits * SAMPLES_PER_BIT_INT) lvl_q.push_back(lvl);
  endtask : put_bits
endmodule : fsd_line_model
`default_nettype wire

// *** fsd_testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fsd_pkg::*;
  logic clk_sys, reset_n, tx_active, frame_done, decode_error, rx, line_busy;
  logic bit_strobe, bit_value, chan_idle, ce_start, pot_frame, pot_idle, seq_err, sym_en, wake_en;
  logic [31:0] frame_contents, exp_contents;
  logic [UTICK_W-1:0] sec_stamp, utick, u_prev, exp_prim;
  fsd_mode_t mode;
  fsd_cfg_t cfg;
  fsd_frame_ind_t frame_ind;
  int mismatches = 0, checks = 0, seed = 39190, gap = 0;
  int got_ce = 0, got_pi = 0, got_pf = 0, got_err = 0, got_fd = 0;
  int exp_ce = 0, exp_pi = 0, exp_pf = 0, exp_err = 0, exp_fd = 0;
  int got_lo = 0, exp_lo = 0;
  bit gap_ok = 0;

  fsd_line_model i_line (.clk_in(clk_sys), .rst_n_in(reset_n), .rx_out(rx), .busy_out(line_busy));

  fsd_frame_start_decoder i_dut (
    .CLK_SYS_IN(clk_sys), .RESET_N_IN(reset_n), .MODE_IN(mode), .TX_ACTIVE_IN(tx_active),
    .VOTED_RX_IN(rx), .CFG_IN(cfg), .FRAME_DONE_IN(frame_done),
    .FRAME_CONTENTS_IN(frame_contents), .DECODE_ERROR_IN(decode_error),
    .BIT_STROBE_OUT(bit_strobe), .BIT_VALUE_OUT(bit_value), .CHANNEL_IDLE_OUT(chan_idle),
    .CE_START_OUT(ce_start), .POT_FRAME_START_OUT(pot_frame), .POT_IDLE_START_OUT(pot_idle),
    .SECONDARY_REF_STAMP_OUT(sec_stamp), .FRAME_DECODED_OUT(frame_ind),
    .START_SEQ_ERROR_OUT(seq_err), .SYMBOL_DECODE_EN_OUT(sym_en),
    .WAKEUP_DETECT_EN_OUT(wake_en), .UTICK_COUNT_OUT(utick));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("counts: checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic give_up();
    mismatches++;
    conclude();
  endtask : give_up

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Monitor sees pre-edge values of registered outputs
  always @(posedge clk_sys)
  begin
    u_prev <= utick;
    if (!reset_n)
      gap_ok = 0;
    else
    begin
      gap++;
      if (utick !== u_prev)
      begin
        if (gap_ok)
        begin
          check(gap, cfg.samples_per_utick);
          check(utick, UTICK_W'(u_prev + 1'b1));
        end
        gap = 0;
        gap_ok = 1;
      end
      if (pot_frame === 1'b1)
      begin
        got_pf++;
        check(sec_stamp, u_prev);
        check(sym_en, 1'b0);
        exp_prim = UTICK_W'(u_prev - cfg.decode_correction - cfg.delay_compensation);
      end
      if (frame_ind.valid === 1'b1)
      begin
        got_fd++;
        check(frame_ind.contents, exp_contents);
        check(frame_ind.primary_ref_stamp, exp_prim);
      end
      if (ce_start === 1'b1)
      begin
        got_ce++;
        check({chan_idle, bit_value}, 2'h0);
      end
      if (pot_idle === 1'b1)
      begin
        got_pi++;
        check(bit_value, 1'b1);
      end
      if (seq_err === 1'b1)
        got_err++;
      if (bit_strobe === 1'b1 && bit_value === 1'b0)
        got_lo++;
    end
  end

  initial
  begin : main
    int n;
    int h;
    int cyc;
    bit ok;
    reset_n = 1'b0;
    mode = FSD_NORMAL;
    tx_active = 1'b0;
    frame_done = 1'b0;
    decode_error = 1'b0;
    frame_contents = 32'h0000_0000;
    exp_contents = 32'h0000_0000;
    cfg.tx_start_seq_len = 4'($unsigned($random(seed)) % 4 + 1);
    cfg.samples_per_utick = 3'($unsigned($random(seed)) % 7 + 1);
    cfg.decode_correction = UTICK_W'($random(seed));
    cfg.delay_compensation = UTICK_W'($random(seed));
    repeat (6) @(posedge clk_sys);
    check({bit_value, chan_idle, sym_en, wake_en}, 4'hA);
    check({sec_stamp, utick}, 32'h0000_0000);
    reset_n <= 1'b1;
    $display("test reset_values done");

    cyc = 0;
    while (chan_idle !== 1'b1 && cyc < 200)
    begin
      @(posedge clk_sys);
      cyc++;
    end
    check(cyc >= 87 && cyc <= 92, 1'b1);
    if (cyc >= 200)
      give_up();
    check(wake_en, 1'b1);
    $display("test idle_detect done");

    for (n = 1; n <= cfg.tx_start_seq_len + 3; n++)
    begin
      for (h = 1; h <= 4; h++)
      begin
        ok = (n <= cfg.tx_start_seq_len + 2) && (h <= 3);
        i_line.put_bits(1'b0, n);
        i_line.put_bits(1'b1, h);
        i_line.put_bits(1'b0, 1);
        i_line.put_bits(1'b1, 14);
        exp_ce++;
        exp_pi += 2;
        exp_lo += n + 1;
        exp_pf += ok;
        exp_err += !ok;
        cyc = 0;
        while (pot_frame !== 1'b1 && cyc < (n + h + 3) * 8)
        begin
          @(posedge clk_sys);
          cyc++;
        end
        if (ok)
        begin
          if (pot_frame !== 1'b1)
            give_up();
          exp_contents = $random(seed);
          frame_contents <= exp_contents;
          frame_done <= 1'b1;
          decode_error <= (h == 2);
          exp_fd += (h != 2);
          @(posedge clk_sys);
          frame_done <= 1'b0;
          decode_error <= 1'b0;
        end
        cyc = 0;
        while ((line_busy || chan_idle !== 1'b1) && cyc < 300)
        begin
          @(posedge clk_sys);
          cyc++;
        end
        if (cyc >= 300)
          give_up();
        check(sym_en, 1'b1);
        check(got_ce, exp_ce);
        check(got_pi, exp_pi);
        check(got_pf, exp_pf);
        check(got_err, exp_err);
        check(got_fd, exp_fd);
        check(got_lo, exp_lo);
      end
    end
    $display("test frame_starts done");

    tx_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(wake_en, 1'b0);
    tx_active <= 1'b0;
    mode <= FSD_READY;
    repeat (3) @(posedge clk_sys);
    check(wake_en, 1'b1);
    mode <= FSD_STANDBY;
    repeat (3) @(posedge clk_sys);
    check(wake_en, 1'b0);
    $display("test wakeup_enable done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
